// ==== design/sacc_ctrl.sv ====
// Purpose: control, result bus and serial output of a SAR converter
// Assumes: comparator decision arrives as a level on comp_in
// Notes:   bus pins carry separate data out and output enable
`timescale 1ns/10ps
`include "sacc_defines.svh"
module sacc_ctrl
  import sacc_pkg::*;
#(
  parameter int RES_BITS   = `SACC_RES_BITS,
  parameter int CAL_CYCLES = `SACC_CAL_CYCLES,
  parameter int TRACK_CYC  = `SACC_TRACK_CYC,
  parameter int BIT_CYC    = `SACC_BIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        reset_in,
  input  wire logic        hold_n,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        result_or_status_sel,
  input  wire logic        bus_width_sel,
  input  wire logic        cal_in,
  input  wire logic        interleave_cal_n,
  input  wire logic        polarity_sel,
  input  wire logic        comp_in,
  output logic      [15:0] data_out,
  output logic      [15:0] data_oe_n,
  output logic             end_of_track_n,
  output logic             end_of_conv,
  output logic             serial_result_out,
  output logic             serial_clk,
  output logic             calibrating
);
  // ******************************************************************
  // pin synchronisers
  // ******************************************************************
  logic [9:0] pin_s;   // settled pins; idle-high ones kept inverted so reset reads idle
  sacc_sync #(.W(10)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .d       ({reset_in, hold_n, cs_n, rd_n, result_or_status_sel, bus_width_sel,
                cal_in, interleave_cal_n, comp_in, polarity_sel} ^ 10'h1C4),
    .q       (pin_s)
  );
  logic rst_s, hold_s, cs_s, rd_s, sel_s, bw_s, cal_s, ilv_s, comp_s, pol_s;
  assign {rst_s, hold_s, cs_s, rd_s, sel_s, bw_s, cal_s, ilv_s, comp_s, pol_s} = pin_s ^ 10'h1C4;

  // ******************************************************************
  // state record
  // ******************************************************************
  typedef struct packed {
    sacc_mode_t          mode;       // main activity
    logic                rst_d;      // reset sample; the reset branch zeroes it, so it always reads low
    logic                hold_d;     // hold pin last cycle
    logic                cs_d;       // chip select last cycle
    logic                rd_act_d;   // read cycle active last cycle
    logic                cal_lat;    // calibrate latched on cs rise
    logic                ilv_lat;    // interleave latched on cs rise
    logic                burst;      // burst calibration enabled
    logic                ilv_on;     // interleave calibration enabled
    logic [20:0]         cal_pos;    // calibration progress, kept across bursts
    logic [RES_BITS-1:0] sar;        // approximation register
    logic [RES_BITS-1:0] result;     // last finished result
    logic [3:0]          bit_idx;    // bit being decided
    logic [7:0]          tick;       // cycles within a bit step
    logic [8:0]          trk_cnt;    // acquisition time counter
    logic                byte_lo;    // next byte read returns low part
    logic                eoc;        // end of conversion pin
    logic                eot_n;      // end of track pin
    logic                sdo;        // serial data pin
    logic                sck;        // serial clock pin
    logic [15:0]         dout;       // data bus value
    logic [15:0]         doe_n;      // data bus enables, low drives
  } sacc_st_t;
  sacc_st_t st_ff;
  sacc_st_t nxt_st;

  logic hold_fall;   // conversion start request
  logic cs_rise;     // latch calibration controls
  logic cs_fall;     // apply calibration controls
  logic rd_act;      // read cycle in progress
  logic rd_end;      // read cycle just finished
  logic [7:0] status; // status byte
  logic [RES_BITS-1:0] code; // result with polarity coding

  assign hold_fall = st_ff.hold_d & ~hold_s;
  assign cs_rise   = ~st_ff.cs_d & cs_s;
  assign cs_fall   = st_ff.cs_d & ~cs_s;
  assign rd_act    = ~cs_s & ~rd_s;
  assign rd_end    = st_ff.rd_act_d & ~rd_act;
  // straight binary internally; two's complement flips the sign bit
  assign code      = pol_s ? (st_ff.result ^ {1'b1, {(RES_BITS-1){1'b0}}})
                           : st_ff.result;

  // status byte: busy, calibrating, tracked, byte phase, interleave
  always_comb begin
    status = 8'h00;
    status[`SACC_ST_BUSY]  = (st_ff.mode == SACC_CONV);
    status[`SACC_ST_CAL]   = st_ff.mode[1];
    status[`SACC_ST_TRACK] = ~st_ff.eot_n;
    status[`SACC_ST_BYTE]  = st_ff.byte_lo;
    status[`SACC_ST_ILV]   = st_ff.ilv_on;
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.rst_d    = rst_s;
      nxt_st.hold_d   = hold_s;
      nxt_st.cs_d     = cs_s;
      nxt_st.rd_act_d = rd_act;
      // chip select rise latches controls; ignored while high
      if (cs_rise) begin
        nxt_st.cal_lat = cal_s;
        nxt_st.ilv_lat = ilv_s;
      end
      if (cs_fall) begin
        nxt_st.burst  = st_ff.cal_lat;
        nxt_st.ilv_on = ~st_ff.ilv_lat;
      end
      // acquisition timer runs only while idle
      if (st_ff.mode == SACC_IDLE && st_ff.eot_n) begin
        if (st_ff.trk_cnt >= 9'(TRACK_CYC - 1)) begin
          nxt_st.eot_n = 1'b0;
        end else begin
          nxt_st.trk_cnt = st_ff.trk_cnt + 9'h001;
        end
      end
      // the first read after completion raises the flag again
      if (rd_end) begin
        nxt_st.eoc = 1'b1;
      end
      // bus: drive only while both selects are low
      nxt_st.doe_n = 16'hFFFF;
      nxt_st.dout  = 16'h0000;
      if (rd_act) begin
        if (!sel_s) begin
          nxt_st.dout  = {8'h00, status};
          nxt_st.doe_n = 16'hFF00;
        end else if (bw_s) begin
          nxt_st.dout  = 16'(code);
          nxt_st.doe_n = 16'h0000;
        end else begin
          nxt_st.dout  = st_ff.byte_lo ? {8'h00, code[3:0], 4'h0}
                                       : {8'h00, code[11:4]};
          nxt_st.doe_n = 16'hFF00;
        end
      end
      if (rd_end && sel_s && !bw_s) begin
        nxt_st.byte_lo = ~st_ff.byte_lo;
      end
      unique case (st_ff.mode)
        SACC_IDLE: begin
          nxt_st.sck = 1'b0;
          if (st_ff.burst) begin
            nxt_st.mode = SACC_CAL;
          end else if (hold_fall) begin
            nxt_st.mode    = SACC_CONV;
            nxt_st.eoc     = 1'b1;
            nxt_st.sar     = '0;
            nxt_st.bit_idx = 4'(RES_BITS - 1);
            nxt_st.tick    = '0;
            nxt_st.eot_n   = 1'b1;
          end
        end
        SACC_CONV: begin
          // one bit per step; clock low first half, high second half
          nxt_st.tick = st_ff.tick + 8'h01;
          if (st_ff.tick == 8'h00) begin
            nxt_st.sar[st_ff.bit_idx] = comp_s;
            nxt_st.sdo = comp_s;
            nxt_st.sck = 1'b0;
          end else if (st_ff.tick == 8'(BIT_CYC / 2)) begin
            nxt_st.sck = 1'b1;
          end else if (st_ff.tick == 8'(BIT_CYC - 1)) begin
            nxt_st.tick = '0;
            if (st_ff.bit_idx == 4'h0) begin
              nxt_st.mode    = SACC_IDLE;
              nxt_st.result  = st_ff.sar;
              nxt_st.eoc     = 1'b0;
              nxt_st.byte_lo = 1'b0;
              nxt_st.trk_cnt = '0;
            end else begin
              nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
            end
          end
        end
        SACC_CAL: begin
          // progress kept when burst stops, so the next resumes
          if (!st_ff.burst) begin
            nxt_st.mode    = SACC_IDLE;
            nxt_st.trk_cnt = '0;
            nxt_st.eot_n   = 1'b1;
          end else if (st_ff.cal_pos == 21'(CAL_CYCLES - 1)) begin
            nxt_st.cal_pos = '0;
          end else begin
            nxt_st.cal_pos = st_ff.cal_pos + 21'h000001;
          end
        end
        SACC_RCAL: begin
          // full calibration after reset; ends with flag low
          if (st_ff.cal_pos == 21'(CAL_CYCLES - 1)) begin
            nxt_st.cal_pos = '0;
            nxt_st.mode    = SACC_IDLE;
            nxt_st.eoc     = 1'b0;
            nxt_st.trk_cnt = '0;
          end else begin
            nxt_st.cal_pos = st_ff.cal_pos + 21'h000001;
          end
        end
      endcase
      // reset pin high reloads reset values and enters full calibration; the count runs from its fall
      if (rst_s) begin
        nxt_st       = '0;
        nxt_st.ilv_lat = 1'b1;
        nxt_st.eoc   = 1'b1;
        nxt_st.eot_n = 1'b1;
        nxt_st.hold_d = hold_s;
        nxt_st.cs_d  = cs_s;
        nxt_st.doe_n = 16'hFFFF;
        nxt_st.mode  = SACC_RCAL;
      end
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{mode: SACC_RCAL, rst_d: 1'b0, hold_d: 1'b1, cs_d: 1'b1,
                 eoc: 1'b1, eot_n: 1'b1, ilv_lat: 1'b1, doe_n: 16'hFFFF, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_out          = st_ff.dout;
  assign data_oe_n         = st_ff.doe_n;
  assign end_of_track_n    = st_ff.eot_n;
  assign end_of_conv       = st_ff.eoc;
  assign serial_result_out = st_ff.sdo;
  assign serial_clk        = st_ff.sck;
  assign calibrating       = st_ff.mode[1];
endmodule

// ==== design/sacc_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk_sys
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
module sacc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage
    logic [W-1:0] s2;  // settled stage
  } sacc_sync_t;
  sacc_sync_t st_ff;
  sacc_sync_t nxt_st;
  // shift by one stage per enabled edge
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule

// ==== pkg/sacc_defines.svh ====
// Purpose: constants for the converter control and output block
// Assumes: 50 MHz system clock
// Notes:   the track count derives from its printed time and the clock rate; calibration and bit counts are given directly
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH
`define SACC_CLK_MHZ        50
`define SACC_RES_BITS       12
`define SACC_CAL_CYCLES     1443840
`define SACC_TRACK_NS       3750
`define SACC_TRACK_CYC      ((`SACC_TRACK_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_HOLD_EXTRA_NS  50
`define SACC_BIT_CYC        4
`define SACC_ST_BUSY        0
`define SACC_ST_CAL         1
`define SACC_ST_TRACK       2
`define SACC_ST_BYTE        3
`define SACC_ST_ILV         4
`endif

// ==== pkg/sacc_pkg.sv ====
// Purpose: types for the converter control and output block
// Assumes: nothing
// Notes:   state codes written out in binary
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_IDLE = 2'b00,
    SACC_CONV = 2'b01,
    SACC_CAL  = 2'b10,
    SACC_RCAL = 2'b11
  } sacc_mode_t;
endpackage

// ==== testbench/sacc_ctrl_monitor.sv ====
// Purpose: protocol checker for the converter control block
// Assumes: bound to sacc_ctrl; one clock domain; BIT_CYC of 4
// Notes:   pins pass two sync flops, so bus windows span 4 cycles
`timescale 1ns/10ps
module sacc_ctrl_monitor #(
  parameter int RES_BITS = 12
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        reset_in,
  input wire logic        hold_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        result_or_status_sel,
  input wire logic        bus_width_sel,
  input wire logic [15:0] data_oe_n,
  input wire logic        end_of_conv,
  input wire logic        serial_result_out,
  input wire logic        serial_clk,
  input wire logic        calibrating
);
  // ****************************************
  // helper logic and sequences
  // ****************************************
  logic [7:0] bits_ff;  // serial clock rises in this busy period
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // count restarts on every busy period so reads cannot inflate it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) bits_ff <= 8'h00;
    else if ($rose(end_of_conv)) bits_ff <= 8'h00;
    else if ($rose(serial_clk)) bits_ff <= bits_ff + 8'h01;
  end
  sequence s_status_rd;
    (!cs_n && !rd_n && !result_or_status_sel)[*4];
  endsequence
  sequence s_byte_rd;
    (!cs_n && !rd_n && !bus_width_sel)[*4];
  endsequence
  sequence s_quiet;
    (cs_n && hold_n && !reset_in)[*6] ##0 !end_of_conv;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  AST_BUS_IDLE: assert property (cs_n[*4] |-> data_oe_n == 16'hFFFF)
    else $error("bus driven while deselected");
  AST_STATUS_OE: assert property (s_status_rd |-> data_oe_n == 16'hFF00)
    else $error("status read not on low byte only");
  AST_BYTE_OE: assert property (s_byte_rd |-> data_oe_n[15:8] == 8'hFF)
    else $error("byte read drives upper lines");
  AST_SDO_AT_RISE: assert property ($rose(serial_clk) |-> $stable(serial_result_out))
    else $error("serial data moved at clock rise");
  AST_SDO_CHANGE: assert property ($changed(serial_result_out) |-> !serial_clk)
    else $error("serial data changed with clock high");
  AST_SCK_PULSE: assert property ($rose(serial_clk) |=> serial_clk ##1 !serial_clk)
    else $error("serial clock pulse width wrong");
  AST_CAL_NO_SCK: assert property (calibrating |-> !serial_clk)
    else $error("serial clock during calibration");
  AST_BIT_COUNT: assert property ($fell(end_of_conv) && bits_ff != 8'h00
                                  |-> bits_ff == 8'(RES_BITS))
    else $error("wrong number of serial bits");
  AST_EOC_HOLD: assert property (s_quiet |=> !end_of_conv)
    else $error("completion flag rose with no cause");
endmodule

// ==== testbench/sacc_host_model.sv ====
// Purpose: host side source of the hold strobe
// Assumes: fire is a one-cycle request from the bench
// Notes:   strobe kept low four clocks, over one clock plus 50 ns
`timescale 1ns/10ps
module sacc_host_model (
  input  wire logic clk_sys,
  input  wire logic fire,
  output logic      hold_n
);
  logic [2:0] low_ff = 3'h0;  // remaining low time of the strobe
  initial hold_n = 1'b1;
  // a short strobe could be missed by the two sync flops
  always @(posedge clk_sys) begin
    if (fire) low_ff <= 3'h4;
    else if (low_ff != 3'h0) low_ff <= low_ff - 3'h1;
    hold_n <= (low_ff <= 3'h1) && !fire;
  end
endmodule

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: comparator modelled as a constant level per conversion
// Notes:   calibration count shortened to 50 cycles
`timescale 1ns/10ps
module tb;
  import sacc_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, reset_in = 1'b0, cs_n = 1'b1, rd_n = 1'b1;
  logic sel = 1'b1, bw = 1'b1, cal_in = 1'b0, pol = 1'b0, comp = 1'b0, fire = 1'b0, ilv_n = 1'b1;
  logic hold_n, eot_n, eoc, sdo, sck, cal_busy;
  logic [15:0] dq, oe_n, d, oe;
  int num_errors = 0, n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  sacc_host_model u_host (.clk_sys(clk_sys), .fire(fire), .hold_n(hold_n));
  sacc_ctrl #(.CAL_CYCLES(50)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
    .reset_in(reset_in), .hold_n(hold_n), .cs_n(cs_n), .rd_n(rd_n),
    .result_or_status_sel(sel), .bus_width_sel(bw), .cal_in(cal_in),
    .interleave_cal_n(ilv_n), .polarity_sel(pol), .comp_in(comp), .data_out(dq),
    .data_oe_n(oe_n), .end_of_track_n(eot_n), .end_of_conv(eoc),
    .serial_result_out(sdo), .serial_clk(sck), .calibrating(cal_busy));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the completion flag, sampled at the quiet edge
  task automatic wait_eoc(input logic lvl, input int lim);
    for (int i = 0; i < lim && eoc !== lvl; i++) @(negedge clk_sys);
    check({15'h0, eoc}, {15'h0, lvl});
    if (eoc !== lvl) tally_and_finish();
  endtask
  task automatic kick(input logic c, input logic p);
    @(posedge clk_sys) comp <= c;
    pol <= p;
    fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
  endtask
  task automatic conv(input logic c, input logic p);
    kick(c, p);
    wait_eoc(1'b1, 10);
    wait_eoc(1'b0, 100);
  endtask
  // read cycle held four clocks so the synced bus settles
  task automatic rd(input logic a, input logic w);
    @(posedge clk_sys) sel <= a;
    bw <= w;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (4) @(negedge clk_sys);
    d = dq;
    oe = oe_n;
    @(posedge clk_sys) cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  // chip select pulse latching the calibrate level
  task automatic cs_pulse(input logic c);
    @(posedge clk_sys) cal_in <= c;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  // every decided bit matches the comparator level
  always @(posedge sck) check({15'h0, sdo}, {15'h0, comp});
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_eoc(1'b0, 200);
    check({15'h0, cal_busy}, 16'h0000);
    conv(1'b1, 1'b0);
    check({15'h0, eot_n}, 16'h0001);
    rd(1'b1, 1'b1);
    check({4'h0, d[11:0]}, 16'h0FFF);
    check({4'h0, oe[11:0]}, 16'h0000);
    check({15'h0, eoc}, 16'h0001);
    conv(1'b1, 1'b1);
    for (int k = 0; k < 3; k++) begin
      rd(1'b1, 1'b0);
      check({8'h0, d[7:0]}, (k == 1) ? 16'h00F0 : 16'h007F);
    end
    repeat (200) @(negedge clk_sys);
    check({15'h0, eot_n}, 16'h0000);
    @(posedge clk_sys) ilv_n <= 1'b0;
    rd(1'b0, 1'b1);
    check(oe, 16'hFF00);
    check({11'h0, d[4:0]}, 16'h000C);
    cs_pulse(1'b1);
    cs_pulse(1'b1);
    check({15'h0, cal_busy}, 16'h0001);
    kick(1'b0, 1'b0);
    repeat (80) @(posedge clk_sys);
    cs_pulse(1'b0);
    cs_pulse(1'b0);
    check({15'h0, cal_busy}, 16'h0000);
    rd(1'b1, 1'b1);
    check({4'h0, d[11:0]}, 16'h0FFF);
    rd(1'b0, 1'b1);
    check({11'h0, d[4:0]}, 16'h0018);
    kick(1'b0, 1'b0);
    cs_pulse(1'b1);
    cs_pulse(1'b1);
    check({14'h0, eoc, cal_busy}, 16'h0002);
    wait_eoc(1'b0, 60);
    repeat (4) @(negedge clk_sys);
    check({15'h0, cal_busy}, 16'h0001);
    cs_pulse(1'b0);
    cs_pulse(1'b0);
    @(posedge clk_sys) reset_in <= 1'b1;
    repeat (4) @(negedge clk_sys);
    check({14'h0, eoc, cal_busy}, 16'h0003);
    @(posedge clk_sys) reset_in <= 1'b0;
    wait_eoc(1'b0, 200);
    tally_and_finish();
  end
endmodule
bind sacc_ctrl sacc_ctrl_monitor #(.RES_BITS(RES_BITS)) u_mon (.clk_sys(clk_sys),
  .rstn(rstn), .reset_in(reset_in), .hold_n(hold_n), .cs_n(cs_n), .rd_n(rd_n),
  .result_or_status_sel(result_or_status_sel), .bus_width_sel(bus_width_sel),
  .data_oe_n(data_oe_n), .end_of_conv(end_of_conv), .serial_clk(serial_clk),
  .serial_result_out(serial_result_out), .calibrating(calibrating));
